// file: sbp_defs.vh
/*
 Constants of the basic flash parameter table store: command code,
 table placement, byte offsets, table contents and field positions.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SBP_DEFS_VH
`define SBP_DEFS_VH

// ==========================================================
// Command and placement
`define SBP_CMD_READ_PARAM   8'h5A
`define SBP_TABLE_START      8'h30
`define SBP_TABLE_END        8'h53
`define SBP_ADDR_BYTES       3
`define SBP_DUMMY_BITS       8

// ==========================================================
// Byte offsets
`define SBP_OFS_ERASE_CFG    8'h30
`define SBP_OFS_ERASE4K_OP   8'h31
`define SBP_OFS_READ_MODES   8'h32
`define SBP_OFS_UNUSED_33    8'h33
`define SBP_OFS_DENS_0       8'h34
`define SBP_OFS_DENS_1       8'h35
`define SBP_OFS_DENS_2       8'h36
`define SBP_OFS_DENS_3       8'h37
`define SBP_OFS_Q144_WM      8'h38
`define SBP_OFS_Q144_OP      8'h39
`define SBP_OFS_Q114_WM      8'h3A
`define SBP_OFS_Q114_OP      8'h3B
`define SBP_OFS_D112_WM      8'h3C
`define SBP_OFS_D112_OP      8'h3D
`define SBP_OFS_D122_WM      8'h3E
`define SBP_OFS_D122_OP      8'h3F
`define SBP_OFS_ALL_RD       8'h40
`define SBP_OFS_D222_WM      8'h46
`define SBP_OFS_D222_OP      8'h47
`define SBP_OFS_Q444_WM      8'h4A
`define SBP_OFS_Q444_OP      8'h4B
`define SBP_OFS_SECT1_SIZE   8'h4C
`define SBP_OFS_SECT1_OP     8'h4D
`define SBP_OFS_SECT2_SIZE   8'h4E
`define SBP_OFS_SECT2_OP     8'h4F
`define SBP_OFS_SECT3_SIZE   8'h50
`define SBP_OFS_SECT3_OP     8'h51
`define SBP_OFS_SECT4_SIZE   8'h52
`define SBP_OFS_SECT4_OP     8'h53

// ==========================================================
// Fields of the first table byte
`define SBP_ERASE_SIZE_4K    2'h1
`define SBP_WRITE_GRAN_64B   1'h1
`define SBP_VOL_WEN_REQ      1'h0
`define SBP_VOL_WEN_OP_50    1'h0
`define SBP_FIRST_UNUSED     3'h7

// ==========================================================
// Wait-state and mode-bit fields (wait in [4:0], mode in [7:5])
`define SBP_WAIT_W           5
`define SBP_MODE_W           3
`define SBP_Q144_WAIT        5'h04
`define SBP_Q144_MODE        3'h2
`define SBP_Q114_WAIT        5'h08
`define SBP_Q114_MODE        3'h0
`define SBP_D112_WAIT        5'h08
`define SBP_D112_MODE        3'h0
`define SBP_D122_WAIT        5'h02
`define SBP_D122_MODE        3'h2
`define SBP_NONE_WAIT        5'h00
`define SBP_NONE_MODE        3'h0

// ==========================================================
// Byte values
`define SBP_VAL_ERASE4K_OP   8'h20
`define SBP_VAL_READ_MODES   8'hF1
`define SBP_VAL_Q144_OP      8'hEB
`define SBP_VAL_Q114_OP      8'h6B
`define SBP_VAL_D112_OP      8'h3B
`define SBP_VAL_D122_OP      8'hBB
`define SBP_VAL_ALL_RD       8'hEE
`define SBP_VAL_NO_OP        8'hFF
`define SBP_VAL_UNUSED       8'hFF
`define SBP_VAL_SECT1_SIZE   8'h0C
`define SBP_VAL_SECT1_OP     8'h20
`define SBP_VAL_SECT2_SIZE   8'h0F
`define SBP_VAL_SECT2_OP     8'h52
`define SBP_VAL_SECT3_SIZE   8'h10
`define SBP_VAL_SECT3_OP     8'hD8
`define SBP_VAL_SECT_ABSENT  8'h00
`define SBP_VAL_DENS_0       8'hFF
`define SBP_VAL_DENS_1       8'hFF
`define SBP_VAL_DENS_2       8'hFF
`define SBP_VAL_DENS_3       8'h00

`endif

// file: sbp_host_model.sv
/*
 Host side of the serial link: frames parameter reads, collects bytes.
 Assumes a 100 ns core clock; the link clock runs at 800 ns, idle low.
*/
`timescale 1ns/1ps
module sbp_host_model (
  input  wire i_core_clk,  // Pacing clock
  input  wire i_so,        // Data from store
  input  wire i_so_oe,     // Store drives data
  output reg  o_sclk,      // Serial clock
  output reg  o_cs_n,      // Chip select
  output reg  o_si         // Data to store
);
  reg [7:0] rx_q[$];
  reg       oe_seen;
  initial begin
    o_sclk  = 1'b0;
    o_cs_n  = 1'b1;
    o_si    = 1'b0;
    oe_seen = 1'b0;
  end
  always @(posedge i_core_clk) begin
    if (i_so_oe) begin
      oe_seen = 1'b1;
    end
  end
  // Half a link period: four core cycles
  task automatic half();
    repeat (4) @(posedge i_core_clk);
    #1;
  endtask
  task automatic bit_io(input b, output r);
    o_si = b;
    half();
    r = i_so;
    o_sclk = 1'b1;
    half();
    o_sclk = 1'b0;
  endtask
  task automatic frame(input [7:0] cmd, input [23:0] adr, input [7:0] dmy, input int n);
    reg [39:0] hdr;
    reg        r;
    reg [7:0]  b;
    hdr     = {cmd, adr, dmy};
    oe_seen = 1'b0;
    o_cs_n  = 1'b0;
    for (int i = 39; i >= 0; i--) begin
      bit_io(hdr[i], r);
    end
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(~o_si, r);
        b[i] = r;
      end
      rx_q.push_back(b);
    end
    half();
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    half();
  endtask
endmodule // sbp_host_model

// file: sbp_param_store.v
/*
 Serial front end of the basic parameter table store. Decodes the
 parameter-read command, a 3-byte address and eight dummy clocks, then
 shifts table bytes out MSB first while the address increments.
 Assumes mode 0 serial timing, a serial clock well below the core clock
 rate, and that all serial pins are asynchronous to i_core_clk.
 A deselect at any point drops back to command decoding; each sclk half
 period must span at least four core clocks for the synchronisers.
*/
// What this block does
// (R1) Parameter bytes are read with command 5AH over the serial interface.
// (R2) The basic parameter table starts at byte offset 30H.
// (R3) Offset 30H returns E5H; low two bits 01b mean 4 KB erase.
// (R4) Bit 2 of first byte reads 1: program granularity 64 bytes or more.
// (R5) Bits 3 and 4 of first byte read 0; opcode 50H enables volatile writes.
// (R6) Bits 7:5 of first byte always read 111b.
// (R7) Offset 32H returns F1H describing read modes and 3-byte addressing.
// (R8) Offsets 38H/39H return 44H and opcode EBH.
// (R9) Offsets 3AH/3BH return 08H and opcode 6BH.
// (R10) Offsets 3CH/3DH return 08H and opcode 3BH.
// (R11) Offsets 3EH/3FH return 42H and opcode BBH.
// (R12) Offset 40H returns EEH; 46H/4AH read 00H, 47H/4BH read FFH.
// (R13) Zero wait and mode fields mean that feature is unsupported.
// (R14) Offsets 4CH/4DH return size 0CH and opcode 20H.
// (R15) Offsets 4EH/4FH return size 0FH and opcode 52H.
// (R16) Offsets 50H/51H return size 10H and opcode D8H.
// (R17) Offsets 52H/53H return 00H and FFH: sector type 4 absent.
// (R18) Unused bytes return FFH; the address increments per byte read.
`timescale 1ns/1ps
`include "sbp_defs.vh"

module sbp_param_store #(
  parameter ADDR_W = 24                  // Width of the serial address
) (
  input  wire i_core_clk,                // Core clock, 10 MHz
  input  wire i_rst,                     // Asynchronous reset, active high
  input  wire i_sclk,                    // Serial clock from host
  input  wire i_cs_n,                    // Chip select, active low
  input  wire i_si,                      // Serial data in
  output wire o_so,                      // Serial data out
  output wire o_so_oe,                   // Serial data output enable
  output wire [7:0] o_table_start_pointer // Table start offset
);

  // ==========================================================
  // States
  localparam [4:0] ST_CMD   = 5'h01;
  localparam [4:0] ST_ADDR  = 5'h02;
  localparam [4:0] ST_DUMMY = 5'h04;
  localparam [4:0] ST_DATA  = 5'h08;
  localparam [4:0] ST_IDLE  = 5'h10;

  // Last bit index of each field; bit_cnt_ff is five bits, so ADDR_W <= 32
  localparam integer ADDR_LAST_I  = ADDR_W - 1;
  localparam integer DUMMY_LAST_I = `SBP_DUMMY_BITS - 1;
  localparam [4:0]   CMD_LAST     = 5'd7;
  localparam [4:0]   ADDR_LAST    = ADDR_LAST_I[4:0];
  localparam [4:0]   DUMMY_LAST   = DUMMY_LAST_I[4:0];
  localparam [4:0]   BYTE_LAST    = 5'd7;

  reg  [2:0]        sclk_sy_ff;
  reg  [1:0]        cs_sy_ff;
  reg  [1:0]        si_sy_ff;
  reg  [4:0]        state_ff;
  reg  [4:0]        nxt_state;
  reg  [4:0]        bit_cnt_ff;
  reg  [4:0]        nxt_bit_cnt;
  reg  [7:0]        cmd_ff;
  reg  [7:0]        nxt_cmd;
  reg  [ADDR_W-1:0] addr_ff;
  reg  [ADDR_W-1:0] nxt_addr;
  reg  [7:0]        shift_ff;
  reg  [7:0]        nxt_shift;
  reg               oe_ff;
  reg               nxt_oe;
  wire [7:0]        rom_data;
  wire              sclk_rise;
  wire              sclk_fall;
  wire              cs_act;
  wire [7:0]        rom_addr;
  wire [7:0]        cmd_next;
  wire              cmd_match;
  wire              byte_last;
  wire [ADDR_W-1:0] addr_inc;

  // ==========================================================
  // Pin synchronisers and edge detect on stage two and three
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_sy_ff <= 3'h0;
      cs_sy_ff   <= 2'h3;
      si_sy_ff   <= 2'h0;
    end else begin
      sclk_sy_ff <= {sclk_sy_ff[1:0], i_sclk};
      cs_sy_ff   <= {cs_sy_ff[0], i_cs_n};
      si_sy_ff   <= {si_sy_ff[0], i_si};
    end
  end

  assign sclk_rise = sclk_sy_ff[1] & ~sclk_sy_ff[2];
  assign sclk_fall = ~sclk_sy_ff[1] & sclk_sy_ff[2];
  assign cs_act    = ~cs_sy_ff[1];
  // Out-of-range high address bits fall on unused bytes
  assign rom_addr  = (|addr_ff[ADDR_W-1:8]) ? 8'hFF : addr_ff[7:0];

  sbp_rom u_rom (
    .i_addr (rom_addr),
    .o_data (rom_data)
  );

  // ==========================================================
  // Field decode
  assign cmd_next  = {cmd_ff[6:0], si_sy_ff[1]};
  assign cmd_match = (cmd_next == `SBP_CMD_READ_PARAM); // R1
  assign byte_last = (bit_cnt_ff == BYTE_LAST);
  assign addr_inc  = addr_ff + {{(ADDR_W-1){1'b0}}, 1'b1}; // R18

  // ==========================================================
  // Command sequencer
  always @* begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_cmd     = cmd_ff;
    nxt_addr    = addr_ff;
    nxt_shift   = shift_ff;
    nxt_oe      = oe_ff;
    if (!cs_act) begin
      nxt_state   = ST_CMD;
      nxt_bit_cnt = 5'h0;
      nxt_oe      = 1'b0;
    end else begin
      case (state_ff)
        ST_CMD: begin
          if (sclk_rise) begin
            nxt_cmd     = cmd_next;
            nxt_bit_cnt = bit_cnt_ff + 5'h1;
            if (bit_cnt_ff == CMD_LAST) begin
              nxt_bit_cnt = 5'h0;
              if (cmd_match) // R1
                nxt_state = ST_ADDR;
              else
                nxt_state = ST_IDLE;
            end
          end
        end
        ST_ADDR: begin
          if (sclk_rise) begin
            nxt_addr    = {addr_ff[ADDR_W-2:0], si_sy_ff[1]};
            nxt_bit_cnt = bit_cnt_ff + 5'h1;
            if (bit_cnt_ff == ADDR_LAST) begin
              nxt_bit_cnt = 5'h0;
              nxt_state   = ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          if (sclk_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 5'h1;
            if (bit_cnt_ff == DUMMY_LAST) begin
              nxt_bit_cnt = 5'h0;
              nxt_state   = ST_DATA;
              nxt_shift   = rom_data;
            end
          end
        end
        ST_DATA: begin
          if (sclk_fall) begin
            nxt_oe = 1'b1;
            if (oe_ff) begin
              nxt_shift   = {shift_ff[6:0], 1'b1};
              nxt_bit_cnt = bit_cnt_ff + 5'h1;
              if (byte_last) begin
                nxt_bit_cnt = 5'h0;
                nxt_shift   = rom_data;
              end
            end
          end
          if (sclk_rise && byte_last)
            nxt_addr = addr_inc; // R18
        end
        ST_IDLE: nxt_state = ST_IDLE;
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Sequencer and header registers
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff   <= ST_CMD;
      bit_cnt_ff <= 5'h0;
      cmd_ff     <= 8'h00;
      addr_ff    <= {ADDR_W{1'b0}};
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      cmd_ff     <= nxt_cmd;
      addr_ff    <= nxt_addr;
    end
  end

  // ==========================================================
  // Read-out registers; the pin idles high and undriven out of reset
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_ff   <= 8'hFF;
      oe_ff      <= 1'b0;
    end else begin
      shift_ff   <= nxt_shift;
      oe_ff      <= nxt_oe;
    end
  end

  // ==========================================================
  // Outputs
  assign o_so    = shift_ff[7];
  assign o_so_oe = oe_ff;
  assign o_table_start_pointer = `SBP_TABLE_START; // R2

endmodule // sbp_param_store

// file: sbp_param_store_monitor.sv
/*
 Checker of the parameter store serial port.
 Assumes it is bound to sbp_param_store and sees its ports only.
*/
`timescale 1ns/1ps
module sbp_param_store_monitor #(
  parameter ADDR_W = 24                   // Address width
) (
  input wire       i_core_clk,            // Core clock
  input wire       i_rst,                 // Reset
  input wire       i_sclk,                // Serial clock
  input wire       i_cs_n,                // Chip select
  input wire       i_si,                  // Data in
  input wire       o_so,                  // Data out
  input wire       o_so_oe,               // Data out enable
  input wire [7:0] o_table_start_pointer  // Table start
);
  // ==========================================================
  // Header capture
  reg  [2:0]  sclk_ff;
  reg  [1:0]  cs_ff;
  reg  [5:0]  cnt_ff;
  reg  [39:0] hdr_ff;
  wire [23:0] adr = hdr_ff[31:8];
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_ff <= 3'h0;
      cs_ff   <= 2'h3;
      cnt_ff  <= 6'h00;
      hdr_ff  <= 40'h00_0000_0000;
    end else begin
      sclk_ff <= {sclk_ff[1:0], i_sclk};
      cs_ff   <= {cs_ff[0], i_cs_n};
      if (cs_ff[1]) begin
        cnt_ff <= 6'h00;
      end else if (sclk_ff[1] && !sclk_ff[2] && cnt_ff < 6'h28) begin
        cnt_ff <= cnt_ff + 6'h01;
        hdr_ff <= {hdr_ff[38:0], i_si};
      end
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_start_pointer: assert property (o_table_start_pointer == 8'h30)
    else $error("table start pointer wrong");
  a_header_length: assert property ($rose(o_so_oe) |-> cnt_ff == 6'h28)
    else $error("output enabled before full header");
  a_read_command: assert property ($rose(o_so_oe) |-> hdr_ff[39:32] == 8'h5A)
    else $error("output enabled for another command");
  a_oe_release: assert property ($rose(i_cs_n) |-> ##[1:5] !o_so_oe)
    else $error("output enable held after deselect");
  a_first_e5: assert property ($rose(o_so_oe) && adr == 24'h00_0030 |-> ##2 o_so)
    else $error("first table bit wrong");
  a_sect1_size: assert property ($rose(o_so_oe) && adr == 24'h00_004C |-> ##2 !o_so)
    else $error("sector one size bit wrong");
  a_sect4_absent: assert property ($rose(o_so_oe) && adr == 24'h00_0052 |-> ##2 !o_so)
    else $error("sector four size bit wrong");
  a_high_addr_ff: assert property ($rose(o_so_oe) && adr[23:8] != 16'h0000 |-> ##2 o_so)
    else $error("high address byte not FFH");
endmodule // sbp_param_store_monitor

bind sbp_param_store sbp_param_store_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_si(i_si),
  .o_so(o_so), .o_so_oe(o_so_oe), .o_table_start_pointer(o_table_start_pointer));

// file: sbp_rom.v
/*
 Combinational lookup of one byte of the basic parameter table.
 Assumes the caller presents a byte offset of the parameter space.
*/
`timescale 1ns/1ps
`include "sbp_defs.vh"

module sbp_rom (
  input  wire [7:0] i_addr,   // Byte offset in parameter space
  output reg  [7:0] o_data    // Table byte at that offset
);

  // ==========================================================
  // Packed wait-state and mode-bit byte
  function [7:0] sbp_wm;
    input [`SBP_WAIT_W-1:0] wait_n;
    input [`SBP_MODE_W-1:0] mode_n;
    begin
      sbp_wm = {mode_n, wait_n}; // R13
    end
  endfunction

  always @* begin
    case (i_addr)
      `SBP_OFS_ERASE_CFG : o_data = {`SBP_FIRST_UNUSED, `SBP_VOL_WEN_OP_50, `SBP_VOL_WEN_REQ,
                                     `SBP_WRITE_GRAN_64B, `SBP_ERASE_SIZE_4K}; // R3 R4 R5 R6
      `SBP_OFS_ERASE4K_OP: o_data = `SBP_VAL_ERASE4K_OP;
      `SBP_OFS_READ_MODES: o_data = `SBP_VAL_READ_MODES; // R7
      `SBP_OFS_DENS_0    : o_data = `SBP_VAL_DENS_0;
      `SBP_OFS_DENS_1    : o_data = `SBP_VAL_DENS_1;
      `SBP_OFS_DENS_2    : o_data = `SBP_VAL_DENS_2;
      `SBP_OFS_DENS_3    : o_data = `SBP_VAL_DENS_3;
      `SBP_OFS_Q144_WM   : o_data = sbp_wm(`SBP_Q144_WAIT, `SBP_Q144_MODE); // R8
      `SBP_OFS_Q144_OP   : o_data = `SBP_VAL_Q144_OP; // R8
      `SBP_OFS_Q114_WM   : o_data = sbp_wm(`SBP_Q114_WAIT, `SBP_Q114_MODE); // R9
      `SBP_OFS_Q114_OP   : o_data = `SBP_VAL_Q114_OP; // R9
      `SBP_OFS_D112_WM   : o_data = sbp_wm(`SBP_D112_WAIT, `SBP_D112_MODE); // R10
      `SBP_OFS_D112_OP   : o_data = `SBP_VAL_D112_OP; // R10
      `SBP_OFS_D122_WM   : o_data = sbp_wm(`SBP_D122_WAIT, `SBP_D122_MODE); // R11
      `SBP_OFS_D122_OP   : o_data = `SBP_VAL_D122_OP; // R11
      `SBP_OFS_ALL_RD    : o_data = `SBP_VAL_ALL_RD; // R12
      `SBP_OFS_D222_WM   : o_data = sbp_wm(`SBP_NONE_WAIT, `SBP_NONE_MODE); // R12
      `SBP_OFS_D222_OP   : o_data = `SBP_VAL_NO_OP; // R12
      `SBP_OFS_Q444_WM   : o_data = sbp_wm(`SBP_NONE_WAIT, `SBP_NONE_MODE); // R12
      `SBP_OFS_Q444_OP   : o_data = `SBP_VAL_NO_OP; // R12
      `SBP_OFS_SECT1_SIZE: o_data = `SBP_VAL_SECT1_SIZE; // R14
      `SBP_OFS_SECT1_OP  : o_data = `SBP_VAL_SECT1_OP; // R14
      `SBP_OFS_SECT2_SIZE: o_data = `SBP_VAL_SECT2_SIZE; // R15
      `SBP_OFS_SECT2_OP  : o_data = `SBP_VAL_SECT2_OP; // R15
      `SBP_OFS_SECT3_SIZE: o_data = `SBP_VAL_SECT3_SIZE; // R16
      `SBP_OFS_SECT3_OP  : o_data = `SBP_VAL_SECT3_OP; // R16
      `SBP_OFS_SECT4_SIZE: o_data = `SBP_VAL_SECT_ABSENT; // R17
      `SBP_OFS_SECT4_OP  : o_data = `SBP_VAL_NO_OP; // R17
      default            : o_data = `SBP_VAL_UNUSED; // R18
    endcase
  end

endmodule // sbp_rom

// file: sbp_tb.sv
/*
 Testbench of the parameter store: reads through the host model and
 compares each byte of a 5AH read with a table model. Assumes a 10 MHz core clock.
*/
`timescale 1ns/1ps
module tb;
  reg        i_core_clk = 1'b0;
  reg        i_rst      = 1'b1;
  wire       sclk, cs_n, si, so, so_oe;
  wire [7:0] tsp;
  reg [31:0] rng        = 32'h362a_1614;
  reg [7:0]  bad [0:3]  = '{8'h03, 8'h0B, 8'h5B, 8'hDA};
  int        n_mismatch = 0;
  int        num_checks = 0;
  int        cycles     = 0;
  always #50 i_core_clk = ~i_core_clk;
  sbp_param_store #(.ADDR_W(24)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe), .o_table_start_pointer(tsp));
  sbp_host_model host (.i_core_clk(i_core_clk), .i_so(so), .i_so_oe(so_oe), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_si(si));
  function automatic [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function automatic [7:0] exp_byte(input [23:0] a);
    if (a[23:8] != 16'h0000) return 8'hFF;
    case (a[7:0])
      8'h30: return 8'hE5;
      8'h31: return 8'h20;
      8'h32: return 8'hF1;
      8'h37: return 8'h00;
      8'h38: return 8'h44;
      8'h39: return 8'hEB;
      8'h3A, 8'h3C: return 8'h08;
      8'h3B: return 8'h6B;
      8'h3D: return 8'h3B;
      8'h3E: return 8'h42;
      8'h3F: return 8'hBB;
      8'h40: return 8'hEE;
      8'h46, 8'h4A, 8'h52: return 8'h00;
      8'h4C: return 8'h0C;
      8'h4D: return 8'h20;
      8'h4E: return 8'h0F;
      8'h4F: return 8'h52;
      8'h50: return 8'h10;
      8'h51: return 8'hD8;
      default: return 8'hFF;
    endcase
  endfunction
  task automatic check(input [7:0] got, input [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic read_chk(input [7:0] cmd, input [23:0] a, input int n);
    rng = xs(rng);
    host.frame(cmd, a, rng[7:0], n);
    check({7'h00, host.oe_seen}, {7'h00, cmd == 8'h5A});
    for (int k = 0; k < n; k++) begin
      if (cmd == 8'h5A) check(host.rx_q.pop_front(), exp_byte(a + k));
    end
    host.rx_q.delete();
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    repeat (3) @(posedge i_core_clk);
    #1;
    check(tsp, 8'h30);
    read_chk(8'h5A, 24'h00_002E, 40);
    read_chk(8'h5A, 24'h00_0030, 1);
    read_chk(8'h5A, 24'h00_004C, 2);
    read_chk(8'h5A, 24'h00_0052, 2);
    read_chk(8'h5A, 24'h01_0030, 2);
    read_chk(8'h5A, 24'hFF_FFFF, 2);
    repeat (12) begin
      rng = xs(rng);
      read_chk(8'h5A, {16'h0000, 8'h28 + {2'h0, rng[5:0]}}, 1 + rng[9:8]);
    end
    foreach (bad[i]) read_chk(bad[i], 24'h00_0030, 1);
    rng = xs(rng);
    read_chk((rng[7:0] == 8'h5A) ? 8'hA5 : rng[7:0], 24'h00_0030, 1);
    wrap_up();
  end
endmodule // tb
